// ==== common/afe_regs_pkg.sv ====
package afe_regs_pkg;

    // =========================================================
    // Register offsets
    localparam logic [7:0] PROT_ENABLE_ADDR = 8'h30;
    localparam logic [7:0] PROT_FLAGS_ADDR = 8'h31;
    localparam logic [7:0] OUT_LOW_ADDR = 8'h32;
    localparam logic [7:0] OUT_HIGH_ADDR = 8'h33;
    localparam logic [7:0] IN_LOW_ADDR = 8'h34;
    localparam logic [7:0] IN_HIGH_ADDR = 8'h35;
    localparam logic [7:0] EDGE_ENABLE_ADDR = 8'h36;
    localparam logic [7:0] PIN_FLAGS_ADDR = 8'h37;
    localparam logic [7:0] SM_CONTROL_ADDR = 8'h38;
    localparam logic [7:0] HYS_PINS89_ADDR = 8'h39;
    localparam logic [7:0] HYS7_BLANK_ADDR = 8'h3A;

    // =========================================================
    // Reset and unmapped read value
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // =========================================================
    // Protection bit positions
    localparam int BRAKE_INPUT_BIT = 7;
    localparam int HIGH_SIDE_PAIR2_BIT = 6;
    localparam int HIGH_SIDE_PAIR1_BIT = 5;
    localparam int HIGH_SIDE_PAIR0_BIT = 4;
    localparam int DRIVER_DISABLE_BIT = 3;
    localparam int LOW_SIDE_PAIR2_BIT = 2;
    localparam int LOW_SIDE_PAIR1_BIT = 1;
    localparam int LOW_SIDE_PAIR0_BIT = 0;
    // Live flag bits per variant; the others are plain storage
    localparam logic [7:0] PROT_LIVE_PLAIN = 8'h77;
    localparam logic [7:0] PROT_LIVE_BRAKE = 8'h99;

    // =========================================================
    // Analog pin fields
    localparam int PIN_COUNT = 10;
    localparam int LOW_PIN_COUNT = 6;
    localparam int EDGE_PIN_COUNT = 4;
    localparam int FIRST_EDGE_PIN = 6;
    localparam int RISE_ENABLE_LSB = 4;
    localparam int FALL_ENABLE_LSB = 0;
    localparam logic [9:0] BRAKE_UNUSED_PINS = 10'h014;
    localparam int SM_ENABLE_BIT = 0;

    // =========================================================
    // Hysteresis and blanking fields
    localparam int HYS_PIN8_LSB = 4;
    localparam int HYS_PIN9_LSB = 0;
    localparam int HYS_PIN7_LSB = 4;
    localparam int BLANK_LSB = 0;
    localparam int CODE_W = 4;
    localparam int RISE_SEL_LSB = 2;
    localparam int FALL_SEL_LSB = 0;

    localparam logic [7:0] HYS_MV_NORMAL [0:3] = '{
        8'h00, 8'h0A, 8'h14, 8'h28
    };
    localparam logic [7:0] HYS_MV_WIDE [0:3] = '{
        8'h00, 8'h23, 8'h46, 8'h8C
    };

    localparam logic [11:0] BLANK_NS [0:15] = '{
        12'h042, 12'h074, 12'h0D7, 12'h109,
        12'h13A, 12'h16C, 12'h19F, 12'h204,
        12'h236, 12'h269, 12'h301, 12'h367,
        12'h3CD, 12'h4CD, 12'h737, 12'h9A4
    };

    // =========================================================
    // Timing
    localparam int CLOCK_MHZ = 250;
    localparam int NS_PER_US = 1000;

    // Least time, so the cycle count rounds up
    function automatic logic [9:0] blank_cycles(input logic [11:0] ns);
        int t;
        t = (int'(ns) * CLOCK_MHZ + NS_PER_US - 1) / NS_PER_US;
        if (t < 1) begin
            t = 1;
        end
        return t[9:0];
    endfunction

    function automatic logic [7:0] hys_mv(input logic [1:0] sel,
                                         input logic wideScale);
        return wideScale ? HYS_MV_WIDE[sel] : HYS_MV_NORMAL[sel];
    endfunction

endpackage

// ==== verilog/pin_edge_detect.sv ====
`timescale 1ns/1ps
module pin_edge_detect (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic pinIn,
    output logic pinLevel,
    output logic risingEdge,
    output logic fallingEdge
);

    typedef struct packed {
        logic sample;
        logic prev;
    } edge_state_type;

    edge_state_type q;
    edge_state_type d;

    // =========================================================
    // Sample and history
    always_comb begin
        d = q;
        d.sample = pinIn;
        d.prev = q.sample;
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pinLevel = q.sample;
    assign risingEdge = q.sample & ~q.prev;
    assign fallingEdge = ~q.sample & q.prev;

endmodule // pin_edge_detect

// ==== verilog/afe_digital_io_and_fault_irq_regs.sv ====
`timescale 1ns/1ps
module afe_digital_io_and_fault_irq_regs #(
    parameter bit BRAKE_VARIANT = 1'b0
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWriteData,
    output logic [7:0] regReadData,
    output logic regReadValid,
    input wire logic [7:0] protEvent,
    input wire logic [9:0] pinInValue,
    input wire logic hysteresisScaleSelect,
    output logic [9:0] pinOutputValue,
    output logic signalManagerEnable,
    output logic [3:0] pin7HysteresisCode,
    output logic [3:0] pin8HysteresisCode,
    output logic [3:0] pin9HysteresisCode,
    output logic [7:0] pin7RiseHysMv,
    output logic [7:0] pin7FallHysMv,
    output logic [7:0] pin8RiseHysMv,
    output logic [7:0] pin8FallHysMv,
    output logic [7:0] pin9RiseHysMv,
    output logic [7:0] pin9FallHysMv,
    output logic [3:0] comparatorBlankingCode,
    output logic [11:0] blankingTimeNs,
    output logic [9:0] blankingCycles,
    output logic protIrq,
    output logic pinIrq,
    output logic irqRequest
);

    // =========================================================
    // Variant constants
    localparam logic [7:0] PROT_LIVE = BRAKE_VARIANT ?
        afe_regs_pkg::PROT_LIVE_BRAKE : afe_regs_pkg::PROT_LIVE_PLAIN;
    localparam logic [9:0] PIN_USED = BRAKE_VARIANT ?
        ~afe_regs_pkg::BRAKE_UNUSED_PINS : 10'h3FF;

    typedef struct packed {
        logic [7:0] protEnable;
        logic [7:0] protFlags;
        logic [7:0] outLow;
        logic [7:0] outHigh;
        logic [7:0] edgeEnable;
        logic [7:0] pinFlags;
        logic [7:0] smControl;
        logic [7:0] hys89;
        logic [7:0] hys7Blank;
        logic [7:0] readData;
        logic readValid;
        logic [9:0] pinOut;
        logic [7:0] riseMv7;
        logic [7:0] fallMv7;
        logic [7:0] riseMv8;
        logic [7:0] fallMv8;
        logic [7:0] riseMv9;
        logic [7:0] fallMv9;
        logic [11:0] blankNs;
        logic [9:0] blankCyc;
    } regs_type;

    regs_type q;
    regs_type d;

    logic [9:0] pinLevel;
    logic [9:0] pinRise;
    logic [9:0] pinFall;
    logic [3:0] edgeSet;
    logic [3:0] pinIrqEnable;

    // =========================================================
    // Input sampling and edge detection
    genvar gi;
    generate
        for (gi = 0; gi < afe_regs_pkg::PIN_COUNT; gi++) begin : g_pin
            pin_edge_detect u_edge (
                .ref_clk(ref_clk),
                .sys_rst(sys_rst),
                .pinIn(pinInValue[gi]),
                .pinLevel(pinLevel[gi]),
                .risingEdge(pinRise[gi]),
                .fallingEdge(pinFall[gi])
            );
        end
    endgenerate

    // =========================================================
    // Edge qualification for pins 6 to 9
    always_comb begin
        for (int i = 0; i < afe_regs_pkg::EDGE_PIN_COUNT; i++) begin
            edgeSet[i] =
                (pinRise[afe_regs_pkg::FIRST_EDGE_PIN + i] &
                 q.edgeEnable[afe_regs_pkg::RISE_ENABLE_LSB + i]) |
                (pinFall[afe_regs_pkg::FIRST_EDGE_PIN + i] &
                 q.edgeEnable[afe_regs_pkg::FALL_ENABLE_LSB + i]);
            pinIrqEnable[i] =
                q.edgeEnable[afe_regs_pkg::RISE_ENABLE_LSB + i] |
                q.edgeEnable[afe_regs_pkg::FALL_ENABLE_LSB + i];
        end
    end

    // =========================================================
    // Register update
    always_comb begin
        logic [1:0] sel;
        sel = 2'h0;
        d = q;
        d.readValid = 1'b0;

        if (regWrite) begin
            unique case (regAddr)
                afe_regs_pkg::PROT_ENABLE_ADDR: begin
                    d.protEnable = regWriteData;
                end
                afe_regs_pkg::PROT_FLAGS_ADDR: begin
                    // Live bits clear on 1, reserved bits are storage
                    d.protFlags = (q.protFlags & PROT_LIVE & ~regWriteData)
                        | (regWriteData & ~PROT_LIVE);
                end
                afe_regs_pkg::OUT_LOW_ADDR: begin
                    d.outLow = regWriteData;
                end
                afe_regs_pkg::OUT_HIGH_ADDR: begin
                    d.outHigh = regWriteData;
                end
                afe_regs_pkg::EDGE_ENABLE_ADDR: begin
                    d.edgeEnable = regWriteData;
                end
                afe_regs_pkg::PIN_FLAGS_ADDR: begin
                    d.pinFlags = {regWriteData[7:4],
                        q.pinFlags[3:0] & ~regWriteData[3:0]};
                end
                afe_regs_pkg::SM_CONTROL_ADDR: begin
                    d.smControl = regWriteData;
                end
                afe_regs_pkg::HYS_PINS89_ADDR: begin
                    d.hys89 = regWriteData;
                end
                afe_regs_pkg::HYS7_BLANK_ADDR: begin
                    d.hys7Blank = regWriteData;
                end
                default: begin
                end
            endcase
        end

        // Hardware set wins over a clearing write in the same cycle
        d.protFlags = d.protFlags | (protEvent & PROT_LIVE);
        d.pinFlags[3:0] = d.pinFlags[3:0] | edgeSet;

        if (regRead) begin
            d.readValid = 1'b1;
            unique case (regAddr)
                afe_regs_pkg::PROT_ENABLE_ADDR: d.readData = q.protEnable;
                afe_regs_pkg::PROT_FLAGS_ADDR: d.readData = q.protFlags;
                afe_regs_pkg::OUT_LOW_ADDR: d.readData = q.outLow;
                afe_regs_pkg::OUT_HIGH_ADDR: d.readData = q.outHigh;
                afe_regs_pkg::IN_LOW_ADDR: begin
                    d.readData = {2'h0, pinLevel[5:0] & PIN_USED[5:0]};
                end
                afe_regs_pkg::IN_HIGH_ADDR: begin
                    d.readData = {4'h0, pinLevel[9:6]};
                end
                afe_regs_pkg::EDGE_ENABLE_ADDR: d.readData = q.edgeEnable;
                afe_regs_pkg::PIN_FLAGS_ADDR: d.readData = q.pinFlags;
                afe_regs_pkg::SM_CONTROL_ADDR: d.readData = q.smControl;
                afe_regs_pkg::HYS_PINS89_ADDR: d.readData = q.hys89;
                afe_regs_pkg::HYS7_BLANK_ADDR: d.readData = q.hys7Blank;
                default: d.readData = afe_regs_pkg::UNMAPPED_READ;
            endcase
        end

        // Pin drive, unused pins of the brake variant held low
        d.pinOut = {d.outHigh[3:0], d.outLow[5:0]} & PIN_USED;

        // Hysteresis decode per pin: upper selector rising, lower falling
        sel = d.hys7Blank[afe_regs_pkg::HYS_PIN7_LSB +
            afe_regs_pkg::RISE_SEL_LSB +: 2];
        d.riseMv7 = afe_regs_pkg::hys_mv(sel, hysteresisScaleSelect);
        sel = d.hys7Blank[afe_regs_pkg::HYS_PIN7_LSB +
            afe_regs_pkg::FALL_SEL_LSB +: 2];
        d.fallMv7 = afe_regs_pkg::hys_mv(sel, hysteresisScaleSelect);
        sel = d.hys89[afe_regs_pkg::HYS_PIN8_LSB +
            afe_regs_pkg::RISE_SEL_LSB +: 2];
        d.riseMv8 = afe_regs_pkg::hys_mv(sel, hysteresisScaleSelect);
        sel = d.hys89[afe_regs_pkg::HYS_PIN8_LSB +
            afe_regs_pkg::FALL_SEL_LSB +: 2];
        d.fallMv8 = afe_regs_pkg::hys_mv(sel, hysteresisScaleSelect);
        sel = d.hys89[afe_regs_pkg::HYS_PIN9_LSB +
            afe_regs_pkg::RISE_SEL_LSB +: 2];
        d.riseMv9 = afe_regs_pkg::hys_mv(sel, hysteresisScaleSelect);
        sel = d.hys89[afe_regs_pkg::HYS_PIN9_LSB +
            afe_regs_pkg::FALL_SEL_LSB +: 2];
        d.fallMv9 = afe_regs_pkg::hys_mv(sel, hysteresisScaleSelect);

        // Blanking time and its cycle count at the system clock
        d.blankNs = afe_regs_pkg::BLANK_NS[
            d.hys7Blank[afe_regs_pkg::BLANK_LSB +: afe_regs_pkg::CODE_W]];
        d.blankCyc = afe_regs_pkg::blank_cycles(d.blankNs);
    end

    // =========================================================
    // State register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
            q.protEnable <= afe_regs_pkg::REG_RESET;
            q.protFlags <= afe_regs_pkg::REG_RESET;
            q.readData <= afe_regs_pkg::REG_RESET;
            q.blankNs <= afe_regs_pkg::BLANK_NS[0];
            q.blankCyc <= afe_regs_pkg::blank_cycles(
                afe_regs_pkg::BLANK_NS[0]);
        end else begin
            q <= d;
        end
    end

    // =========================================================
    // Outputs
    assign regReadData = q.readData;
    assign regReadValid = q.readValid;
    assign pinOutputValue = q.pinOut;
    assign signalManagerEnable = q.smControl[afe_regs_pkg::SM_ENABLE_BIT];
    assign pin7HysteresisCode =
        q.hys7Blank[afe_regs_pkg::HYS_PIN7_LSB +: afe_regs_pkg::CODE_W];
    assign pin8HysteresisCode =
        q.hys89[afe_regs_pkg::HYS_PIN8_LSB +: afe_regs_pkg::CODE_W];
    assign pin9HysteresisCode =
        q.hys89[afe_regs_pkg::HYS_PIN9_LSB +: afe_regs_pkg::CODE_W];
    assign pin7RiseHysMv = q.riseMv7;
    assign pin7FallHysMv = q.fallMv7;
    assign pin8RiseHysMv = q.riseMv8;
    assign pin8FallHysMv = q.fallMv8;
    assign pin9RiseHysMv = q.riseMv9;
    assign pin9FallHysMv = q.fallMv9;
    assign comparatorBlankingCode =
        q.hys7Blank[afe_regs_pkg::BLANK_LSB +: afe_regs_pkg::CODE_W];
    assign blankingTimeNs = q.blankNs;
    assign blankingCycles = q.blankCyc;

    // Request follows the stored flags and enables
    assign protIrq = |(q.protFlags & q.protEnable & PROT_LIVE);
    assign pinIrq = |(q.pinFlags[3:0] & pinIrqEnable);
    assign irqRequest = protIrq | pinIrq;

endmodule // afe_digital_io_and_fault_irq_regs

// ==== tb/afe_regs_host.sv ====
`timescale 1ns/1ps
module afe_regs_host (
    input wire logic ref_clk,
    input wire logic [7:0] regReadData,
    input wire logic regReadValid,
    output logic [7:0] regAddr,
    output logic regWrite,
    output logic regRead,
    output logic [7:0] regWriteData
);
    // ==========
    // Register port master, each task entered just after a rising edge
    initial begin
        regAddr = 8'hFF;
        regWrite = 1'b0;
        regRead = 1'b0;
        regWriteData = 8'h00;
    end
    // Idle address and data are inverted so stale values are never reused
    // An idle cycle ends each request so no strobe toggles in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr = a;
        regWriteData = d;
        regWrite = 1'b1;
        @(posedge ref_clk);
        #1;
        regWrite = 1'b0;
        regAddr = ~a;
        regWriteData = ~d;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output bit ok);
        regAddr = a;
        regRead = 1'b1;
        ok = 1'b0;
        d = 8'h00;
        @(posedge ref_clk);
        #1;
        regRead = 1'b0;
        regAddr = ~a;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (regReadValid === 1'b1) begin
                d = regReadData;
                ok = 1'b1;
            end else begin
                @(posedge ref_clk);
                #1;
            end
        end
        @(posedge ref_clk);
        #1;
    endtask
endmodule // afe_regs_host

// ==== tb/afe_regs_assertions.sv ====
`timescale 1ns/1ps
module afe_regs_assertions #(
    parameter bit BRAKE_VARIANT = 1'b0
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWriteData,
    input wire logic regReadValid,
    input wire logic [7:0] protEvent,
    input wire logic [9:0] pinInValue,
    input wire logic [9:0] pinOutputValue,
    input wire logic [3:0] pin7HysteresisCode,
    input wire logic [3:0] pin8HysteresisCode,
    input wire logic [3:0] pin9HysteresisCode,
    input wire logic [3:0] comparatorBlankingCode,
    input wire logic protIrq,
    input wire logic pinIrq,
    input wire logic irqRequest
);
    // ==========
    // Shadow of the enables as written on the register port
    logic [7:0] protEn_q;
    logic [7:0] edgeEn_q;
    logic [7:0] live;
    logic [7:0] lowMask;
    assign live = BRAKE_VARIANT ? 8'h99 : 8'h77;
    assign lowMask = BRAKE_VARIANT ? 8'h2B : 8'h3F;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            protEn_q <= 8'h00;
            edgeEn_q <= 8'h00;
        end else if (regWrite && regAddr == 8'h30) begin
            protEn_q <= regWriteData;
        end else if (regWrite && regAddr == 8'h36) begin
            edgeEn_q <= regWriteData;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // ==========
    // Properties
    read_answer_a: assert property (
        regRead |=> regReadValid) else $error("read not answered");
    prot_set_a: assert property (
        (|(protEvent & protEn_q & live)) && !(regWrite && regAddr == 8'h30)
        |=> protIrq) else $error("enabled event gave no irq");
    prot_clear_a: assert property (
        regWrite && regAddr == 8'h31 && regWriteData == 8'hFF
        && protEvent == 8'h00 |=> !protIrq) else $error("flags not cleared");
    irq_merge_a: assert property (
        irqRequest == (protIrq || pinIrq)) else $error("irq merge wrong");
    pin_rise_a: assert property (
        $rose(pinInValue[9]) && edgeEn_q[7] && !regWrite ##1 !regWrite
        |=> pinIrq) else $error("rising edge not flagged");
    pin_fall_a: assert property (
        $fell(pinInValue[6]) && edgeEn_q[0] && !regWrite ##1 !regWrite
        |=> pinIrq) else $error("falling edge not flagged");
    pin_clear_a: assert property (
        regWrite && regAddr == 8'h37 && regWriteData[3:0] == 4'hF
        && $stable(pinInValue) && pinInValue == $past(pinInValue, 2)
        |=> !pinIrq) else $error("pin flags not cleared");
    out_low_a: assert property (
        regWrite && regAddr == 8'h32 |=> {2'b00, pinOutputValue[5:0]}
        == ($past(regWriteData) & lowMask)) else $error("low outputs wrong");
    hys_code_a: assert property (
        regWrite && regAddr == 8'h39 |=> {pin8HysteresisCode,
        pin9HysteresisCode} == $past(regWriteData)) else $error("hys wrong");
    blank_code_a: assert property (
        regWrite && regAddr == 8'h3A |=> {pin7HysteresisCode,
        comparatorBlankingCode} == $past(regWriteData)) else $error("blank");
    cover property (protIrq);
    cover property ($rose(pinIrq));
    cover property (regReadValid);
endmodule // afe_regs_assertions

bind afe_digital_io_and_fault_irq_regs afe_regs_assertions #(
    .BRAKE_VARIANT(BRAKE_VARIANT)
) chk (.ref_clk, .sys_rst, .regAddr, .regWrite, .regRead, .regWriteData,
    .regReadValid, .protEvent, .pinInValue, .pinOutputValue,
    .pin7HysteresisCode, .pin8HysteresisCode, .pin9HysteresisCode,
    .comparatorBlankingCode, .protIrq, .pinIrq, .irqRequest);

// ==== tb/afe_digital_io_and_fault_irq_regs_bench.sv ====
`timescale 1ns/1ps
module afe_digital_io_and_fault_irq_regs_bench;
    logic ref_clk, sys_rst, regWrite, regRead, regReadValid;
    logic [7:0] regAddr, regWriteData, regReadData, protEvent;
    logic [9:0] pinInValue, pinOutputValue, blankingCycles;
    logic hysteresisScaleSelect, signalManagerEnable;
    logic [3:0] pin7HysteresisCode, pin8HysteresisCode, pin9HysteresisCode;
    logic [7:0] pin7RiseHysMv, pin7FallHysMv, pin8RiseHysMv, pin8FallHysMv;
    logic [7:0] pin9RiseHysMv, pin9FallHysMv;
    logic [3:0] comparatorBlankingCode;
    logic [11:0] blankingTimeNs;
    logic protIrq, pinIrq, irqRequest;
    logic [7:0] rdB, mb;
    logic [9:0] pinOutB;
    logic protIrqB, pinIrqB, irqB;
    int n_mismatch = 0;
    int n_tests = 0;
    logic [7:0] m [48:58];
    logic [7:0] a, d, c, ev, e;
    logic [9:0] old, r, f;
    logic [7:0] lst [9] = '{8'h30, 8'h32, 8'h33, 8'h34, 8'h36, 8'h38,
                            8'h39, 8'h3A, 8'h3B};
    logic [7:0] hn [4] = '{8'h00, 8'h0A, 8'h14, 8'h28};
    logic [7:0] hw [4] = '{8'h00, 8'h23, 8'h46, 8'h8C};
    logic [11:0] bt [16] = '{12'h042, 12'h074, 12'h0D7, 12'h109, 12'h13A,
        12'h16C, 12'h19F, 12'h204, 12'h236, 12'h269, 12'h301, 12'h367,
        12'h3CD, 12'h4CD, 12'h737, 12'h9A4};

    afe_digital_io_and_fault_irq_regs #(.BRAKE_VARIANT(1'b0)) dut (
        .ref_clk, .sys_rst, .regAddr, .regWrite, .regRead, .regWriteData,
        .regReadData, .regReadValid, .protEvent, .pinInValue,
        .hysteresisScaleSelect, .pinOutputValue, .signalManagerEnable,
        .pin7HysteresisCode, .pin8HysteresisCode, .pin9HysteresisCode,
        .pin7RiseHysMv, .pin7FallHysMv, .pin8RiseHysMv, .pin8FallHysMv,
        .pin9RiseHysMv, .pin9FallHysMv, .comparatorBlankingCode,
        .blankingTimeNs, .blankingCycles, .protIrq, .pinIrq, .irqRequest);
    afe_digital_io_and_fault_irq_regs #(.BRAKE_VARIANT(1'b1)) dutBrake (
        .ref_clk, .sys_rst, .regAddr, .regWrite, .regRead, .regWriteData,
        .regReadData(rdB), .regReadValid(), .protEvent, .pinInValue,
        .hysteresisScaleSelect, .pinOutputValue(pinOutB),
        .signalManagerEnable(), .pin7HysteresisCode(),
        .pin8HysteresisCode(), .pin9HysteresisCode(), .pin7RiseHysMv(),
        .pin7FallHysMv(), .pin8RiseHysMv(), .pin8FallHysMv(),
        .pin9RiseHysMv(), .pin9FallHysMv(), .comparatorBlankingCode(),
        .blankingTimeNs(), .blankingCycles(), .protIrq(protIrqB),
        .pinIrq(pinIrqB), .irqRequest(irqB));
    afe_regs_host host (.ref_clk, .regReadData, .regReadValid, .regAddr,
        .regWrite, .regRead, .regWriteData);

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // ==========
    // Checking
    task automatic results();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chkReg(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkOut(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t output %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] expRd(input logic [7:0] x);
        if (x == 8'h34) return {2'b00, pinInValue[5:0]};
        if (x == 8'h35) return {4'h0, pinInValue[9:6]};
        if (x >= 8'h30 && x <= 8'h3A) return m[x];
        return 8'h00;
    endfunction
    // Brake variant: pins 2 and 4 absent, own live flag bits
    function automatic logic [7:0] expRdB(input logic [7:0] x);
        if (x == 8'h34) return expRd(x) & 8'h2B;
        if (x == 8'h31) return mb;
        return expRd(x);
    endfunction
    function automatic logic [7:0] mv(input logic [1:0] s);
        return hysteresisScaleSelect ? hw[s] : hn[s];
    endfunction
    task automatic rdc(input logic [7:0] x);
        logic [7:0] v;
        bit ok;
        host.rd(x, v, ok);
        if (!ok) begin
            n_mismatch++;
            results();
        end
        chkReg(v, expRd(x));
        chkReg(rdB, expRdB(x));
    endtask
    task automatic wrm(input logic [7:0] x, input logic [7:0] v);
        host.wr(x, v);
        case (x)
            8'h31: begin
                m[x] = (m[x] & ~v & 8'h77) | (v & 8'h88);
                mb = (mb & ~v & 8'h99) | (v & 8'h66);
            end
            8'h37: m[x] = (m[x] & ~v & 8'h0F) | (v & 8'hF0);
            8'h30, 8'h32, 8'h33, 8'h36, 8'h38, 8'h39, 8'h3A: m[x] = v;
            default: ;
        endcase
    endtask
    task automatic outs();
        int cy;
        logic p, q, pb;
        cy = (int'(bt[m[58][3:0]]) * 250 + 999) / 1000;
        p = |(m[49] & m[48] & 8'h77);
        q = |(m[55][3:0] & (m[54][7:4] | m[54][3:0]));
        pb = |(mb & m[48] & 8'h99);
        chkOut(pinOutputValue, {m[51][3:0], m[50][5:0]});
        chkOut(signalManagerEnable, m[56][0]);
        chkOut({pin7HysteresisCode, pin8HysteresisCode, pin9HysteresisCode,
            comparatorBlankingCode}, {m[58][7:4], m[57], m[58][3:0]});
        chkOut({pin8RiseHysMv, pin8FallHysMv, pin9RiseHysMv, pin9FallHysMv},
            {mv(m[57][7:6]), mv(m[57][5:4]), mv(m[57][3:2]),
            mv(m[57][1:0])});
        chkOut({pin7RiseHysMv, pin7FallHysMv},
            {mv(m[58][7:6]), mv(m[58][5:4])});
        chkOut(blankingTimeNs, bt[m[58][3:0]]);
        chkOut(blankingCycles, 32'(cy));
        chkOut({protIrq, pinIrq, irqRequest}, {p, q, p | q});
        chkOut(pinOutB, {m[51][3:0], m[50][5:0]} & 10'h3EB);
        chkOut({protIrqB, pinIrqB, irqB}, {pb, q, pb | q});
    endtask
    task automatic rst();
        sys_rst = 1'b1;
        foreach (m[i]) m[i] = 8'h00;
        mb = 8'h00;
        repeat (2) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
    endtask
    task automatic scan();
        for (int i = 8'h2F; i <= 8'h3B; i++) rdc(8'(i));
        outs();
    endtask
    // ==========
    // Main sequence
    initial begin
        void'($urandom(32'h3A824914));
        protEvent = 8'h00;
        pinInValue = 10'h000;
        hysteresisScaleSelect = 1'b0;
        rst();
        scan();
        repeat (40) begin
            a = lst[$urandom % 9];
            d = 8'($urandom);
            if (a == 8'h30) d = d & 8'h77;
            hysteresisScaleSelect = 1'($urandom);
            wrm(a, d);
            rdc(a);
            outs();
        end
        wrm(8'h30, 8'h88);
        rdc(8'h30);
        wrm(8'h31, 8'h88);
        rdc(8'h31);
        outs();
        wrm(8'h30, 8'h77);
        repeat (20) begin
            ev = 8'($urandom);
            c = 8'($urandom);
            fork
                wrm(8'h31, c);
                begin
                    protEvent = ev;
                    @(posedge ref_clk);
                    #1;
                    protEvent = 8'h00;
                end
            join
            m[49] = m[49] | (ev & 8'h77);
            mb = mb | (ev & 8'h99);
            rdc(8'h31);
            outs();
        end
        repeat (30) begin
            d = 8'($urandom);
            wrm(8'h36, d);
            old = pinInValue;
            pinInValue = 10'($urandom);
            repeat (2) @(posedge ref_clk);
            #1;
            e = m[54];
            r = pinInValue & ~old;
            f = old & ~pinInValue;
            m[55] |= {4'h0, (r[9:6] & e[7:4]) | (f[9:6] & e[3:0])};
            rdc(8'h37);
            rdc(8'h34);
            rdc(8'h35);
            c = 8'($urandom);
            wrm(8'h37, c);
            outs();
        end
        rst();
        scan();
        results();
    end
endmodule // afe_digital_io_and_fault_irq_regs_bench
